// ===== core/ebu_defines.svh
// Offsets, field positions, reset values and vector numbers of the exception unit
`ifndef EBU_DEFINES_SVH
`define EBU_DEFINES_SVH
`define EBU_OFS_EXT 8'h00
`define EBU_OFS_IDT 8'h04
`define EBU_OFS_FPCS 8'h08
`define EBU_OFS_STAT 8'h0C
`define EBU_OFS_DSTAT 8'h10
`define EBU_OFS_DCTL 8'h14
`define EBU_DE_BIT 3
`define EBU_MCE_BIT 6
`define EBU_FP_MASK_POS 7
`define EBU_BPT_POS 16
`define EBU_EXT_RST 32'h00000000
`define EBU_IDT_RST 16'h07FF
`define EBU_FPCS_RST 32'h00001F80
`define EBU_DCTL_RST 32'h00000000
`define EBU_DSTAT_RST 32'h00000000
`define EBU_DCTL_RSVD 32'h0000D800
`define EBU_DSTAT_RSVD 32'h00001000
`define EBU_BPT_EXEC 2'h0
`define EBU_BPT_WRITE 2'h1
`define EBU_BPT_IO 2'h2
`define EBU_BPT_RW 2'h3
`define EBU_VEC_DIV 8'h00
`define EBU_VEC_DBG 8'h01
`define EBU_VEC_NMI 8'h02
`define EBU_VEC_UD 8'h06
`define EBU_VEC_DF 8'h08
`define EBU_VEC_GP 8'h0D
`define EBU_VEC_PF 8'h0E
`define EBU_VEC_AC 8'h11
`define EBU_VEC_MC 8'h12
`define EBU_VEC_XF 8'h13
`define EBU_MAX_ILEN 5'h0F
`define EBU_QB_MIN 32'hFFFFFF80
`define EBU_QB_MAX 32'h0000007F
`define EBU_QW_MIN 32'hFFFF8000
`define EBU_QW_MAX 32'h00007FFF
`define EBU_RESP_OK 2'h0
`define EBU_RESP_ERR 2'h2
`endif

// ===== core/ebu_pkg.sv
// Types shared by the exception unit and its surroundings
package ebu_pkg;
	typedef enum logic {ebu_run, ebu_shutdown} ebu_mode_type;

	typedef struct packed {
		logic valid;
		logic [31:0] cur_ip;
		logic [31:0] next_ip;
		logic step_trap;
		logic ext_intr;
		logic [7:0] ext_vec;
		logic nmi;
		logic interrupt_return_instr_done;
		logic fetch_pf;
		logic [4:0] instr_len;
		logic lock_bad;
		logic tr_move;
		logic dr_req;
		logic dr_wr;
		logic [2:0] dr_idx;
		logic [31:0] dr_wdata;
		logic div_op;
		logic div_word;
		logic div_zero;
		logic [31:0] div_quot;
		logic simd_fault;
		logic [5:0] simd_cause;
		logic hw_error;
		logic sreg_wr;
		logic [31:0] sreg_wdata;
		logic [31:0] sreg_rsvd;
		logic pte_rsvd;
		logic unaligned;
		logic align_on;
		logic acc_exec;
		logic acc_read;
		logic acc_write;
		logic acc_io;
		logic [31:0] acc_addr;
	} ebu_pipe_type;

	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic double_f;
		logic [31:0] ret_ptr;
	} ebu_exc_type;
endpackage

// ===== core/ebu_core.sv
// Exception, priority and breakpoint unit with an AXI4-Lite register slave
// What this block does
// RULE_01: Type 00 breaks on instruction execution only, 01 on data writes only.
// RULE_02: Type 10 breaks on port accesses when debug extensions on; undefined otherwise.
// RULE_03: Type 11 breaks on data reads or writes, never instruction fetches.
// RULE_04: Third and fourth type encodings are 10 and 11.
// RULE_05: Debug control bits 11, 12, 14, 15 always read zero.
// RULE_06: Debug status bit 12 ignores written ones and stays zero.
// RULE_07: Extensions off: reserved debug indices alias to status and control.
// RULE_08: Extensions on: moves with reserved debug indices raise invalid opcode.
// RULE_09: Any test-register move raises invalid opcode.
// RULE_10: Unmasked vector floating-point fault goes to vector 19, cause recorded.
// RULE_11: Hardware errors raise vector 18 only while machine-check enable set.
// RULE_12: Writing one to reserved special-register bit raises vector 13, no update.
// RULE_13: Reserved bit set in a translation entry raises vector 14.
// RULE_14: Unaligned reference with alignment checking raises vector 17.
// RULE_15: Divide error on vector 0, return pointer at faulting instruction.
// RULE_16: Most negative quotient is a valid signed divide result.
// RULE_17: Illegal bus-lock prefix raises invalid opcode, vector 6.
// RULE_18: Instruction longer than 15 bytes raises general protection.
// RULE_19: Priority: prior traps, interrupts, fetch, decode, then execution faults.
// RULE_20: After an accepted NMI, further NMIs wait for interrupt return.
// RULE_21: Vector entry beyond table limit raises double fault instead.
// RULE_22: Double-fault entry beyond limit enters shutdown.
// RULE_23: Extension control register clears to zero at reset.
// RULE_24: Breakpoint hits go through debug vector at trap or fault priority.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ebu_defines.svh"

module ebu_core #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pipeline side
	input wire ebu_pkg::ebu_pipe_type pipe,
	output ebu_pkg::ebu_exc_type exc,
	output logic dr_done,
	output logic [31:0] dr_rdata,
	output logic sreg_commit,
	output logic shutdown,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	typedef struct packed {
		ebu_pkg::ebu_mode_type mode;
		logic [31:0] ext_ctrl;
		logic [15:0] idt_limit;
		logic [31:0] fp_cs;
		logic [31:0] dctl;
		logic [31:0] dstat;
		logic [3:0][31:0] bp_addr;
		logic nmi_blk;
		logic nmi_pend;
		logic trap_pend;
		ebu_pkg::ebu_exc_type exc;
		logic dr_done;
		logic [31:0] dr_rdata;
		logic sreg_commit;
		logic aw_ok;
		logic w_ok;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ebu_state_type;

	ebu_state_type st;
	ebu_state_type next_st;
	logic de;
	logic machine_check_enable;
	logic [3:0] exec_hit;
	logic [3:0] data_hit;
	logic ev;
	logic is_fault;
	logic take_nmi;
	logic take_trap;
	logic [7:0] vec;
	logic div_bad;
	logic q_low;
	logic q_high;
	logic dr_bad;
	logic [5:0] fp_unmasked;
	logic commit;
	logic [31:0] rd_val;
	logic rd_hit;
	logic nmi_blk_held;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
			begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign de = st.ext_ctrl[`EBU_DE_BIT];
	assign machine_check_enable = st.ext_ctrl[`EBU_MCE_BIT];

	// Per-slot breakpoint match by type encoding
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_slot
			logic en;
			logic [1:0] typ;
			logic match;
			assign en = st.dctl[2*gi] | st.dctl[2*gi+1];
			assign typ = st.dctl[`EBU_BPT_POS+4*gi +: 2];
			assign match = en && pipe.valid && (pipe.acc_addr == st.bp_addr[gi]);
			assign exec_hit[gi] = match && typ == `EBU_BPT_EXEC && pipe.acc_exec; // [RULE_01]
			assign data_hit[gi] = match && ((typ == `EBU_BPT_WRITE && pipe.acc_write) // [RULE_01]
				|| (typ == `EBU_BPT_IO && de && pipe.acc_io) // [RULE_02] [RULE_04]
				|| (typ == `EBU_BPT_RW && (pipe.acc_read || pipe.acc_write))); // [RULE_03]
		end
	endgenerate

	// Quotient range check; the most negative value stays legal
	always_comb
	begin
		if (pipe.div_word)
		begin
			q_low = $signed(pipe.div_quot) < $signed(`EBU_QW_MIN); // [RULE_16]
			q_high = $signed(pipe.div_quot) > $signed(`EBU_QW_MAX);
		end
		else
		begin
			q_low = $signed(pipe.div_quot) < $signed(`EBU_QB_MIN); // [RULE_16]
			q_high = $signed(pipe.div_quot) > $signed(`EBU_QB_MAX);
		end
	end

	assign div_bad = pipe.div_op && (pipe.div_zero || q_low || q_high);
	assign dr_bad = pipe.dr_req && de && pipe.dr_idx[2:1] == 2'h2; // [RULE_08]
	assign fp_unmasked = pipe.simd_cause & ~st.fp_cs[`EBU_FP_MASK_POS +: 6];

	// Event selection: lower categories first, later assignments win
	always_comb
	begin
		ev = 1'b0;
		is_fault = 1'b1;
		take_nmi = 1'b0;
		take_trap = 1'b0;
		vec = `EBU_VEC_DIV;
		if (pipe.simd_fault && fp_unmasked != 6'h00)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_XF; // [RULE_10]
		end
		if (pipe.hw_error && machine_check_enable)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_MC; // [RULE_11]
		end
		if (pipe.unaligned && pipe.align_on)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_AC; // [RULE_14]
		end
		if (pipe.pte_rsvd)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_PF; // [RULE_13]
		end
		if (pipe.sreg_wr && (pipe.sreg_wdata & pipe.sreg_rsvd) != 32'h00000000)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_GP; // [RULE_12]
		end
		if (div_bad)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_DIV; // [RULE_15]
		end
		if (pipe.lock_bad || pipe.tr_move || dr_bad)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_UD; // [RULE_17] [RULE_09] [RULE_08]
		end
		if (pipe.instr_len > `EBU_MAX_ILEN)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_GP; // [RULE_18]
		end
		if (pipe.fetch_pf)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_PF; // [RULE_19]
		end
		if (exec_hit != 4'h0)
		begin
			ev = 1'b1;
			vec = `EBU_VEC_DBG; // [RULE_24]
		end
		if (pipe.ext_intr)
		begin
			ev = 1'b1;
			is_fault = 1'b0;
			vec = pipe.ext_vec; // [RULE_19]
		end
		if (st.nmi_pend && !st.nmi_blk)
		begin
			ev = 1'b1;
			is_fault = 1'b0;
			take_nmi = 1'b1; // [RULE_20]
			vec = `EBU_VEC_NMI;
		end
		if (st.trap_pend || pipe.step_trap)
		begin
			ev = 1'b1;
			is_fault = 1'b0;
			take_nmi = 1'b0;
			take_trap = 1'b1; // [RULE_24] [RULE_19]
			vec = `EBU_VEC_DBG;
		end
		ev = ev && pipe.valid && st.mode == ebu_pkg::ebu_run;
	end

	assign commit = pipe.valid && !ev && st.mode == ebu_pkg::ebu_run;

	// Register read mux
	always_comb
	begin
		rd_hit = 1'b1;
		rd_val = 32'h00000000;
		unique case (s_axi_araddr[7:0])
			`EBU_OFS_EXT: rd_val = st.ext_ctrl;
			`EBU_OFS_IDT: rd_val = {16'h0000, st.idt_limit};
			`EBU_OFS_FPCS: rd_val = st.fp_cs;
			`EBU_OFS_STAT: rd_val = {21'h000000, st.nmi_blk, st.mode == ebu_pkg::ebu_shutdown,
				st.trap_pend, st.exc.vector};
			`EBU_OFS_DSTAT: rd_val = st.dstat;
			`EBU_OFS_DCTL: rd_val = st.dctl;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		next_st = st;
		next_st.exc.valid = 1'b0;
		next_st.dr_done = 1'b0;
		next_st.sreg_commit = 1'b0;
		// AXI write address and data are taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_st.aw_ok = 1'b1;
			next_st.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_st.w_ok = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.aw_ok && st.w_ok)
		begin
			next_st.aw_ok = 1'b0;
			next_st.w_ok = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `EBU_RESP_OK;
			unique case (st.awaddr)
				`EBU_OFS_EXT: next_st.ext_ctrl = merge(st.ext_ctrl, st.wdata, st.wstrb);
				`EBU_OFS_IDT: next_st.idt_limit = 16'(merge({16'h0000, st.idt_limit}, st.wdata,
					st.wstrb));
				`EBU_OFS_FPCS: next_st.fp_cs = merge(st.fp_cs, st.wdata, st.wstrb);
				`EBU_OFS_STAT, `EBU_OFS_DSTAT, `EBU_OFS_DCTL: next_st.bresp = `EBU_RESP_OK;
				default: next_st.bresp = `EBU_RESP_ERR;
			endcase
		end
		if (st.bvalid && s_axi_bready)
		begin
			next_st.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_val;
			next_st.rresp = rd_hit ? `EBU_RESP_OK : `EBU_RESP_ERR;
		end
		else if (st.rvalid && s_axi_rready)
		begin
			next_st.rvalid = 1'b0;
		end
		// Debug register moves commit only on a clean boundary
		if (commit && pipe.dr_req)
		begin
			next_st.dr_done = 1'b1;
			next_st.dr_rdata = pipe.dr_idx[2] ? (pipe.dr_idx[0] ? st.dctl : st.dstat) // [RULE_07]
				: st.bp_addr[pipe.dr_idx[1:0]];
			if (pipe.dr_wr)
			begin
				if (!pipe.dr_idx[2])
				begin
					next_st.bp_addr[pipe.dr_idx[1:0]] = pipe.dr_wdata;
				end
				else if (pipe.dr_idx[0])
				begin
					next_st.dctl = pipe.dr_wdata & ~`EBU_DCTL_RSVD; // [RULE_05] [RULE_07]
				end
				else
				begin
					next_st.dstat = pipe.dr_wdata & ~`EBU_DSTAT_RSVD; // [RULE_06] [RULE_07]
				end
			end
		end
		if (commit && pipe.sreg_wr)
		begin
			next_st.sreg_commit = 1'b1; // [RULE_12]
		end
		// Hardware-set flags are applied last so they beat a clearing write
		if (pipe.valid && pipe.simd_fault)
		begin
			next_st.fp_cs[5:0] = next_st.fp_cs[5:0] | pipe.simd_cause; // [RULE_10]
		end
		next_st.dstat[3:0] = next_st.dstat[3:0] | exec_hit | data_hit;
		if (data_hit != 4'h0)
		begin
			next_st.trap_pend = 1'b1; // [RULE_24]
		end
		else if (ev && take_trap)
		begin
			next_st.trap_pend = 1'b0;
		end
		if (pipe.interrupt_return_instr_done)
		begin
			next_st.nmi_blk = 1'b0; // [RULE_20]
		end
		if (pipe.nmi)
		begin
			next_st.nmi_pend = 1'b1;
		end
		if (ev && take_nmi)
		begin
			next_st.nmi_pend = pipe.nmi;
			next_st.nmi_blk = 1'b1; // [RULE_20]
		end
		// Table limit check with double-fault and shutdown escalation
		if (ev)
		begin
			next_st.exc.ret_ptr = is_fault ? pipe.cur_ip : pipe.next_ip; // [RULE_15]
			if ({5'h00, vec, 3'h7} <= st.idt_limit)
			begin
				next_st.exc.valid = 1'b1;
				next_st.exc.vector = vec;
				next_st.exc.double_f = 1'b0;
			end
			else if ({5'h00, `EBU_VEC_DF, 3'h7} <= st.idt_limit)
			begin
				next_st.exc.valid = 1'b1;
				next_st.exc.vector = `EBU_VEC_DF; // [RULE_21]
				next_st.exc.double_f = 1'b1;
			end
			else
			begin
				next_st.mode = ebu_pkg::ebu_shutdown; // [RULE_22]
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.ext_ctrl <= `EBU_EXT_RST; // [RULE_23]
			st.idt_limit <= `EBU_IDT_RST;
			st.fp_cs <= `EBU_FPCS_RST;
			st.dctl <= `EBU_DCTL_RST;
			st.dstat <= `EBU_DSTAT_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign exc = st.exc;
	assign dr_done = st.dr_done;
	assign dr_rdata = st.dr_rdata;
	assign sreg_commit = st.sreg_commit;
	assign shutdown = st.mode == ebu_pkg::ebu_shutdown;
	assign s_axi_awready = !st.aw_ok && !st.bvalid;
	assign s_axi_wready = !st.w_ok && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_alias_read;
		pipe.valid && !ev && st.mode == ebu_pkg::ebu_run && pipe.dr_req && !pipe.dr_wr && !de
			&& pipe.dr_idx == 3'h4;
	endsequence

	a_dctl_reserved: assert property ((st.dctl & `EBU_DCTL_RSVD) == 32'h0) // [RULE_05]
		else $error("debug control reserved bit set");
	a_dstat_bit12: assert property (!st.dstat[12]) // [RULE_06]
		else $error("debug status bit 12 set");
	a_alias_status: assert property (s_alias_read // [RULE_07]
		|=> dr_done && dr_rdata == $past(st.dstat))
		else $error("reserved index did not alias to status");
	a_reserved_idx: assert property ($past(dr_bad) |-> !dr_done) // [RULE_08]
		else $error("reserved debug index accessed with extensions on");
	a_mc_gate: assert property (exc.valid && exc.vector == `EBU_VEC_MC |-> $past(machine_check_enable)) // [RULE_11]
		else $error("machine check while disabled");
	a_nmi_masked: assert property (nmi_blk_held // [RULE_20]
		|-> !(exc.valid && exc.vector == `EBU_VEC_NMI))
		else $error("second NMI delivered while blocked");
	a_df_vector: assert property (exc.valid && exc.double_f // [RULE_21]
		|-> exc.vector == `EBU_VEC_DF)
		else $error("double fault on wrong vector");
	a_limit_ok: assert property (exc.valid // [RULE_21]
		|-> {5'h00, exc.vector, 3'h7} <= $past(st.idt_limit))
		else $error("vector beyond table limit delivered");
	a_shut_stays: assert property (shutdown |=> shutdown && !exc.valid) // [RULE_22]
		else $error("left shutdown without reset");
	a_ext_reset: assert property (disable iff (1'b0) !rstn |=> st.ext_ctrl == 32'h0) // [RULE_23]
		else $error("extension control not cleared by reset");

	always_ff @(posedge ref_clk)
	begin
		nmi_blk_held <= rstn && st.nmi_blk && next_st.nmi_blk;
	end

endmodule // ebu_core

// ===== tb/ebu_pipe_src.sv
// Instruction pipeline and interrupt source model driving the exception unit
`timescale 1ns/10ps
module ebu_pipe_src (
	// Clock
	input wire logic ref_clk,
	// Events toward the unit
	output ebu_pkg::ebu_pipe_type pipe
);
	ebu_pkg::ebu_pipe_type idle;

	initial
	begin
		pipe = '0;
	end

	// One boundary per call; released fields change so stale values are never seen
	task issue(input ebu_pkg::ebu_pipe_type p);
		@(posedge ref_clk);
		pipe <= p;
		@(posedge ref_clk);
		idle = ~p;
		idle.valid = 1'b0;
		idle.nmi = 1'b0;
		idle.interrupt_return_instr_done = 1'b0;
		pipe <= idle;
	endtask
endmodule // ebu_pipe_src

// ===== tb/ebu_core_test.sv
// Self-checking bench of the exception unit
`timescale 1ns/10ps
`include "ebu_defines.svh"
module ebu_core_test;
	logic ref_clk;
	logic rstn;
	ebu_pkg::ebu_pipe_type pipe;
	ebu_pkg::ebu_pipe_type p;
	ebu_pkg::ebu_exc_type exc;
	logic dr_done, sreg_commit, shutdown, awr, wr, bv, ar, rv, last_df;
	logic awv, wv, br, arv, rr;
	logic [7:0] awaddr, araddr, last_vec;
	logic [31:0] wdata, dr_rdata, rdata, last_ret, last_dr, d;
	logic [1:0] bresp, rresp, r;
	int err_total, compares, n_exc, n_dr, n_sc, c, k;
	logic [7:0] ofs [5] = '{`EBU_OFS_EXT, `EBU_OFS_IDT, `EBU_OFS_FPCS, `EBU_OFS_DSTAT,
		`EBU_OFS_DCTL};
	logic [31:0] rst_val [5] = '{`EBU_EXT_RST, {16'h0, `EBU_IDT_RST}, `EBU_FPCS_RST,
		`EBU_DSTAT_RST, `EBU_DCTL_RST};
	logic [3:0] hits [4] = '{4'b0001, 4'b0010, 4'b1000, 4'b0110};

	ebu_pipe_src i_pipe (.ref_clk(ref_clk), .pipe(pipe));

	ebu_core i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .pipe(pipe), .exc(exc), .dr_done(dr_done),
		.dr_rdata(dr_rdata), .sreg_commit(sreg_commit), .shutdown(shutdown),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(ar),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
	);

	initial
	begin
		ref_clk = 0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial
	begin
		{rstn, awv, wv, br, arv, rr, awaddr, araddr, wdata} = '0;
		{err_total, compares, n_exc, n_dr, n_sc} = '0;
		{last_vec, last_ret, last_df, last_dr} = '0;
	end

	// Records every delivered exception, debug move answer and special write
	always @(posedge ref_clk)
	begin
		if (exc.valid === 1'b1)
		begin
			n_exc <= n_exc + 1;
			last_vec <= exc.vector;
			last_ret <= exc.ret_ptr;
			last_df <= exc.double_f;
		end
		if (dr_done === 1'b1)
		begin
			n_dr <= n_dr + 1;
			last_dr <= dr_rdata;
		end
		if (sreg_commit === 1'b1)
			n_sc <= n_sc + 1;
	end

	task finish_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= v;
		awv <= 1;
		wv <= 1;
		br <= 1;
		do
		begin
			@(posedge ref_clk);
			n++;
			if (awr)
				awv <= 0;
			if (wr)
				wv <= 0;
		end
		while (bv !== 1'b1 && n < 50);
		r = bresp;
		br <= 0;
		if (n >= 50)
			err_total++;
	endtask

	task rd_reg(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arv <= 1;
		rr <= 1;
		do
		begin
			@(posedge ref_clk);
			n++;
			if (ar)
				arv <= 0;
		end
		while (rv !== 1'b1 && n < 50);
		d = rdata;
		r = rresp;
		rr <= 0;
		if (n >= 50)
			err_total++;
	endtask

	task clr;
		p = '0;
		p.valid = 1;
		p.cur_ip = 32'h00001000;
		p.next_ip = 32'h00001004;
	endtask

	// Issues one boundary; 9'h100 means no exception expected
	task ev(input string nm, input logic [8:0] e);
		c = n_exc;
		i_pipe.issue(p);
		repeat (3) @(posedge ref_clk);
		chk(nm, {23'h0, e}, (n_exc == c) ? 32'h100 : {24'h0, last_vec});
	endtask

	task dmv(input logic w, input logic [2:0] i, input logic [31:0] v, input logic [8:0] e);
		clr;
		p.dr_req = 1;
		p.dr_wr = w;
		p.dr_idx = i;
		p.dr_wdata = v;
		ev("debug move", e);
		d = last_dr;
	endtask

	initial
	begin
		repeat (5) @(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk);
		for (k = 0; k < 5; k++)
		begin
			rd_reg(ofs[k]);
			chk("reset value", rst_val[k], d);
		end
		rd_reg(8'h20);
		chk("unmapped resp", {30'h0, `EBU_RESP_ERR}, {30'h0, r});
		wr_reg(`EBU_OFS_IDT, 32'h000000FF);
		chk("write resp", {30'h0, `EBU_RESP_OK}, {30'h0, r});
		$display("test registers done");
		clr;
		p.div_op = 1;
		p.div_zero = 1;
		ev("divide zero", 9'h000);
		chk("divide return", 32'h00001000, last_ret);
		p.div_zero = 0;
		p.div_quot = `EBU_QB_MIN;
		ev("byte most negative", 9'h100);
		p.div_word = 1;
		p.div_quot = `EBU_QW_MIN;
		ev("word most negative", 9'h100);
		p.div_word = 0;
		p.div_quot = 32'h00000080;
		ev("byte overflow", 9'h000);
		clr;
		p.lock_bad = 1;
		ev("bad lock", 9'h006);
		clr;
		p.tr_move = 1;
		ev("test register", 9'h006);
		clr;
		p.instr_len = 5'h0F;
		ev("length 15", 9'h100);
		p.instr_len = 5'h10;
		ev("length 16", 9'h00D);
		clr;
		p.sreg_wr = 1;
		p.sreg_rsvd = 32'h2;
		p.sreg_wdata = 32'h1;
		ev("special ok", 9'h100);
		k = n_sc;
		p.sreg_wdata = 32'h3;
		ev("special reserved", 9'h00D);
		chk("special kept", k, n_sc);
		clr;
		p.pte_rsvd = 1;
		ev("table entry", 9'h00E);
		clr;
		p.unaligned = 1;
		ev("unchecked align", 9'h100);
		p.align_on = 1;
		ev("checked align", 9'h011);
		clr;
		p.simd_fault = 1;
		p.simd_cause = 6'h01;
		ev("masked simd", 9'h100);
		wr_reg(`EBU_OFS_FPCS, 32'h0);
		ev("unmasked simd", 9'h013);
		rd_reg(`EBU_OFS_FPCS);
		chk("simd cause", 32'h1, d);
		clr;
		p.hw_error = 1;
		ev("check off", 9'h100);
		wr_reg(`EBU_OFS_EXT, 32'h40);
		ev("check on", 9'h012);
		$display("test vectors done");
		clr;
		p.step_trap = 1;
		p.ext_intr = 1;
		p.ext_vec = 8'h1F;
		p.fetch_pf = 1;
		p.instr_len = 5'h10;
		p.div_op = 1;
		p.div_zero = 1;
		ev("prio trap", 9'h001);
		chk("trap return", 32'h00001004, last_ret);
		p.step_trap = 0;
		ev("prio intr", 9'h01F);
		p.ext_intr = 0;
		ev("prio fetch", 9'h00E);
		p.fetch_pf = 0;
		ev("prio decode", 9'h00D);
		p.instr_len = 0;
		ev("prio exec", 9'h000);
		clr;
		p.nmi = 1;
		ev("nmi latched", 9'h100);
		ev("nmi first", 9'h002);
		ev("nmi blocked", 9'h100);
		clr;
		p.valid = 0;
		p.interrupt_return_instr_done = 1;
		ev("nmi return", 9'h100);
		clr;
		ev("nmi released", 9'h002);
		rd_reg(`EBU_OFS_STAT);
		chk("status word", 32'h00000402, d);
		$display("test priority done");
		dmv(1, 3'h5, 32'h0000D801, 9'h100);
		dmv(0, 3'h7, 32'h0, 9'h100);
		chk("control bits", 32'h00000001, d);
		dmv(1, 3'h4, `EBU_DSTAT_RSVD, 9'h100);
		dmv(0, 3'h4, 32'h0, 9'h100);
		chk("status bit", 32'h0, d & `EBU_DSTAT_RSVD);
		dmv(1, 3'h0, 32'h00002000, 9'h100);
		wr_reg(`EBU_OFS_EXT, 32'h48);
		k = n_dr;
		dmv(0, 3'h5, 32'h0, 9'h006);
		chk("no move answer", k, n_dr);
		for (int t = 0; t < 4; t++)
		begin
			dmv(1, 3'h7, {14'h0, 2'(t), 16'h0001}, 9'h100);
			for (int a = 0; a < 4; a++)
			begin
				clr;
				p.acc_addr = 32'h00002000;
				{p.acc_io, p.acc_read, p.acc_write, p.acc_exec} = 4'h1 << a;
				k = n_exc;
				i_pipe.issue(p);
				clr;
				ev("trap slot", 9'h100 >> (8 * hits[t][a]));
				chk("breakpoint", hits[t][a], n_exc - k);
			end
		end
		dmv(0, 3'h6, 32'h0, 9'h100);
		chk("hit flag", 32'h1, d & 32'h1);
		$display("test debug done");
		wr_reg(`EBU_OFS_IDT, 32'h00000047);
		clr;
		p.instr_len = 5'h10;
		ev("beyond limit", 9'h008);
		chk("double flag", 32'h1, {31'h0, last_df});
		wr_reg(`EBU_OFS_IDT, 32'h00000040);
		ev("no handler", 9'h100);
		chk("shutdown", 32'h1, {31'h0, shutdown});
		rstn <= 0;
		repeat (5) @(posedge ref_clk);
		rstn <= 1;
		@(posedge ref_clk);
		chk("shutdown cleared", 32'h0, {31'h0, shutdown});
		rd_reg(`EBU_OFS_EXT);
		chk("ext after reset", `EBU_EXT_RST, d);
		$display("test limit done");
		finish_test;
	end

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		finish_test;
	end
endmodule // ebu_core_test
